// [src/t2cap_map.svh]
`ifndef T2CAP_MAP_SVH
`define T2CAP_MAP_SVH
// Function
// - Capture mode counts system clock, clock/12 or external falling edges
// - Capture copies count to reload, sets high flag
// - Capture on falling edge of synchronised external/8
// - Low select and capture enable: count every clock
// - High flag set on high byte rollover
// - Overflow flags cleared only by software write
// - Split mode: run gates high byte only
// - Low interrupt enable adds low-byte overflow request

// =====================================================================
// Register addresses
`define T2CAP_ADDR_CTRL 8'hC8
`define T2CAP_ADDR_RLL 8'hCA
`define T2CAP_ADDR_RLH 8'hCB
`define T2CAP_ADDR_CNTL 8'hCC
`define T2CAP_ADDR_CNTH 8'hCD
// =====================================================================
// Control register fields and reset value
`define T2CAP_HIGH_FLAG 7
`define T2CAP_LOW_FLAG 6
`define T2CAP_LOW_IRQ_EN 5
`define T2CAP_CAPTURE_EN 4
`define T2CAP_SPLIT 3
`define T2CAP_RUN 2
`define T2CAP_EXT_SEL 0
`define T2CAP_CTRL_RESET 8'h00
`define T2CAP_BYTE_MAX 8'hFF
// =====================================================================
// Timing counts
`define T2CAP_DIV12_LAST 4'hB
`endif

// [src/t2cap_pkg.sv]
package t2cap_pkg;
    typedef enum logic [2:0] {
        T2CAP_SRC_SYS = 3'h1,
        T2CAP_SRC_DIV12 = 3'h2,
        T2CAP_SRC_EXT = 3'h4
    } t2cap_src_t;
endpackage

// [src/t2cap_tick.sv]
`timescale 1ns/10ps
`include "t2cap_map.svh"
module t2cap_tick
    import t2cap_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ext_clk_div8,
    output logic div12_tick,
    output logic ext_fall_tick
);
    logic [3:0] div_q;
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;

    // =================================================================
    // Divider and synchroniser
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            div_q <= 4'h0;
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            div_q <= (div_q == `T2CAP_DIV12_LAST) ? 4'h0 : div_q + 4'h1;
            sync1_q <= ext_clk_div8;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign div12_tick = (div_q == `T2CAP_DIV12_LAST);
    assign ext_fall_tick = sync3_q & ~sync2_q;

    // =================================================================
    // Checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    div_period_a: assert property (div12_tick |=> (!div12_tick)[*8] ##1 !div12_tick
        ##1 !div12_tick ##1 !div12_tick ##1 div12_tick)
        else $error("divide by twelve period wrong");
    fall_edge_a: assert property ($fell(sync2_q) |-> ext_fall_tick)
        else $error("falling edge of external clock missed");
endmodule

// [src/t2cap_timer.sv]
`timescale 1ns/10ps
`include "t2cap_map.svh"
module t2cap_timer
    import t2cap_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic low_byte_clock_select,
    input wire logic high_byte_clock_select,
    input wire logic timer_irq_enable,
    input wire logic ext_clk_div8,
    output logic timer2_irq
);
    logic [7:0] ctrl_q;
    logic [7:0] cnt_low_q;
    logic [7:0] cnt_high_q;
    logic [7:0] rl_low_q;
    logic [7:0] rl_high_q;
    logic [7:0] rdata_q;
    logic high_flag_q;
    logic low_flag_q;
    logic div12_tick;
    logic ext_fall_tick;

    t2cap_tick u_tick (
        .clk_sys(clk_sys),
        .reset(reset),
        .ext_clk_div8(ext_clk_div8),
        .div12_tick(div12_tick),
        .ext_fall_tick(ext_fall_tick)
    );

    // =================================================================
    // Field and address decode
    wire low_irq_en = ctrl_q[`T2CAP_LOW_IRQ_EN];
    wire capture_en = ctrl_q[`T2CAP_CAPTURE_EN];
    wire split = ctrl_q[`T2CAP_SPLIT];
    wire run = ctrl_q[`T2CAP_RUN];
    wire ext_sel = ctrl_q[`T2CAP_EXT_SEL];
    wire wr_ctrl = sfr_wr & (sfr_addr == `T2CAP_ADDR_CTRL);
    wire wr_rll = sfr_wr & (sfr_addr == `T2CAP_ADDR_RLL);
    wire wr_rlh = sfr_wr & (sfr_addr == `T2CAP_ADDR_RLH);
    wire wr_cntl = sfr_wr & (sfr_addr == `T2CAP_ADDR_CNTL);
    wire wr_cnth = sfr_wr & (sfr_addr == `T2CAP_ADDR_CNTH);

    // =================================================================
    // Clock source selection
    // select zero defers to external select
    wire ext_or_div = ext_sel ? ext_fall_tick : div12_tick;
    t2cap_src_t low_src;
    assign low_src = low_byte_clock_select ? T2CAP_SRC_SYS :
        (ext_sel ? T2CAP_SRC_EXT : T2CAP_SRC_DIV12);
    wire low_pace = (low_src == T2CAP_SRC_SYS) | ext_or_div;
    wire high_pace = high_byte_clock_select | ext_or_div;
    // low byte always runs in split mode
    wire tick_low = low_pace & (split | run);
    wire low_wrap = tick_low & (cnt_low_q == `T2CAP_BYTE_MAX);
    wire tick_high = split ? (run & high_pace) : low_wrap;
    wire high_wrap = tick_high & (cnt_high_q == `T2CAP_BYTE_MAX);
    wire reload_full = ~split & ~capture_en & high_wrap;
    wire capture = capture_en & ext_fall_tick;

    // =================================================================
    // Next values
    wire [7:0] cnt_low_d = wr_cntl ? sfr_wdata :
        (reload_full | (split & low_wrap)) ? rl_low_q :
        tick_low ? cnt_low_q + 8'h01 : cnt_low_q;
    wire [7:0] cnt_high_d = wr_cnth ? sfr_wdata :
        (reload_full | (split & high_wrap)) ? rl_high_q :
        tick_high ? cnt_high_q + 8'h01 : cnt_high_q;
    wire [7:0] rl_low_d = capture ? cnt_low_q : (wr_rll ? sfr_wdata : rl_low_q);
    wire [7:0] rl_high_d = capture ? cnt_high_q : (wr_rlh ? sfr_wdata : rl_high_q);
    // high flag set wins over clear
    wire high_flag_d = high_wrap | capture |
        (wr_ctrl ? sfr_wdata[`T2CAP_HIGH_FLAG] : high_flag_q);
    wire low_flag_d = low_wrap | (wr_ctrl ? sfr_wdata[`T2CAP_LOW_FLAG] : low_flag_q);
    // control layout, bit one reads zero
    wire [7:0] ctrl_view = {high_flag_q, low_flag_q, ctrl_q[5:2], 1'b0, ctrl_q[0]};
    wire [7:0] rdata_d = (sfr_addr == `T2CAP_ADDR_CTRL) ? ctrl_view :
        (sfr_addr == `T2CAP_ADDR_RLL) ? rl_low_q :
        (sfr_addr == `T2CAP_ADDR_RLH) ? rl_high_q :
        (sfr_addr == `T2CAP_ADDR_CNTL) ? cnt_low_q :
        (sfr_addr == `T2CAP_ADDR_CNTH) ? cnt_high_q : 8'h00;

    // =================================================================
    // Registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_q <= `T2CAP_CTRL_RESET;
            high_flag_q <= 1'b0;
            low_flag_q <= 1'b0;
            cnt_low_q <= 8'h00;
            cnt_high_q <= 8'h00;
            rl_low_q <= 8'h00;
            rl_high_q <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {2'b00, sfr_wdata[5:2], 1'b0, sfr_wdata[0]};
            end
            high_flag_q <= high_flag_d;
            low_flag_q <= low_flag_d;
            cnt_low_q <= cnt_low_d;
            cnt_high_q <= cnt_high_d;
            rl_low_q <= rl_low_d;
            rl_high_q <= rl_high_d;
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata = rdata_q;
    assign timer2_irq = timer_irq_enable & (high_flag_q | (low_irq_en & low_flag_q));

    // =================================================================
    // Checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    capture_copy_a: assert property (capture |=> (rl_low_q == $past(cnt_low_q))
        && (rl_high_q == $past(cnt_high_q)) && high_flag_q)
        else $error("capture did not copy count or set flag");
    sys_count_a: assert property (low_byte_clock_select && capture_en && run
        && !split && !sfr_wr && cnt_low_q != 8'hFF |=> cnt_low_q == $past(cnt_low_q) + 8'h01)
        else $error("counter did not advance every clock");
    high_roll_a: assert property (high_wrap |=> high_flag_q && cnt_high_q != 8'hFF)
        else $error("high rollover did not set flag");
    ctrl_view_a: assert property (sfr_addr == 8'hC8 |=> sfr_rdata[1] == 1'b0
        && sfr_rdata[7] == $past(high_flag_q) && sfr_rdata[2] == $past(run))
        else $error("control register read wrong");
    flag_hold_a: assert property (high_flag_q && low_flag_q && !wr_ctrl
        |=> high_flag_q && low_flag_q) else $error("flag cleared without write");
    div_select_a: assert property (!low_byte_clock_select && !ext_sel && !div12_tick
        && run && !split && !wr_cntl |=> $stable(cnt_low_q))
        else $error("low byte counted without divided tick");
    split_gate_a: assert property (split && !run && !wr_cnth |=> $stable(cnt_high_q))
        else $error("high byte ran while stopped in split mode");
    split_low_a: assert property (split && !run && low_byte_clock_select
        && !wr_cntl && cnt_low_q != 8'hFF |=> cnt_low_q == $past(cnt_low_q) + 8'h01)
        else $error("low byte stopped in split mode");
    low_irq_a: assert property (timer_irq_enable && low_irq_en && low_flag_q
        |-> timer2_irq) else $error("low overflow request missing");

    capture_seen_c: cover property (capture ##[1:300] capture);
    full_reload_c: cover property (reload_full);
    split_wrap_c: cover property (split && low_wrap);
endmodule

// [testbench/t2cap_osc.sv]
`timescale 1ns/10ps
// =====================================================================
// External oscillator divided by eight; it parks high while stopped.
module t2cap_osc (
    input wire logic run,
    output logic ext_clk_div8
);
    initial begin
        ext_clk_div8 = 1'b1;
        forever begin
            #1005;
            if (run || !ext_clk_div8) begin
                ext_clk_div8 = ~ext_clk_div8;
            end
        end
    end
endmodule

// [testbench/testbench.sv]
`timescale 1ns/10ps
`include "t2cap_map.svh"
module testbench;
    logic clk_sys;
    logic reset;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic low_byte_clock_select;
    logic high_byte_clock_select;
    logic timer_irq_enable;
    logic ext_clk_div8;
    logic timer2_irq;
    logic osc_run;
    int n_fail;
    int n_checks;
    t2cap_timer i_dut (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .low_byte_clock_select(low_byte_clock_select),
        .high_byte_clock_select(high_byte_clock_select),
        .timer_irq_enable(timer_irq_enable), .ext_clk_div8(ext_clk_div8),
        .timer2_irq(timer2_irq));
    t2cap_osc i_osc (.run(osc_run), .ext_clk_div8(ext_clk_div8));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // =====================================================================
    // Bus cycles and comparison
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr = a;
        @(negedge clk_sys);
        d = sfr_rdata;
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Waits for a capture, reads the reload pair, then clears the flag.
    task automatic wait_cap(input logic [7:0] ctl, output logic [15:0] c);
        logic [7:0] v;
        logic [7:0] h;
        v = 8'h00;
        for (int i = 0; i < 400 && v[7] !== 1'b1; i++) begin
            rd(`T2CAP_ADDR_CTRL, v);
        end
        if (v[7] !== 1'b1) begin
            chk("capture wait", 16'h0001, 16'h0000);
            summarize();
        end
        rd(`T2CAP_ADDR_RLL, v);
        rd(`T2CAP_ADDR_RLH, h);
        c = {h, v};
        wr(`T2CAP_ADDR_CTRL, ctl);
    endtask
    // =====================================================================
    // Scenarios
    task automatic t_regs();
        logic [7:0] v;
        rd(`T2CAP_ADDR_CTRL, v);
        chk("ctrl reset", 16'h0000, v);
        wr(`T2CAP_ADDR_CTRL, 8'hFF);
        rd(`T2CAP_ADDR_CTRL, v);
        chk("ctrl fields", 16'h00FD, v);
        rd(8'hC9, v);
        chk("unmapped", 16'h0000, v);
    endtask
    task automatic t_cap(input logic sel, input logic [7:0] ctl, input logic [15:0] lo,
        input logic [15:0] hi);
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] d;
        low_byte_clock_select = sel;
        wr(`T2CAP_ADDR_CTRL, ctl);
        osc_run = 1'b1;
        wait_cap(ctl, a);
        wait_cap(ctl, b);
        osc_run = 1'b0;
        d = b - a;
        chk("capture delta", (d == hi) ? hi : lo, d);
    endtask
    task automatic t_ovf();
        logic [7:0] v;
        low_byte_clock_select = 1'b1;
        timer_irq_enable = 1'b1;
        wr(`T2CAP_ADDR_CTRL, 8'h20);
        wr(`T2CAP_ADDR_CNTH, 8'hFF);
        wr(`T2CAP_ADDR_CNTL, 8'hFE);
        wr(`T2CAP_ADDR_CTRL, 8'h24);
        repeat (6) @(negedge clk_sys);
        rd(`T2CAP_ADDR_CTRL, v);
        chk("rollover flags", 16'h00E4, v);
        chk("irq set", 16'h0001, timer2_irq);
        repeat (40) @(negedge clk_sys);
        rd(`T2CAP_ADDR_CTRL, v);
        chk("flags held", 16'h00E4, v);
        wr(`T2CAP_ADDR_CTRL, 8'h00);
        rd(`T2CAP_ADDR_CTRL, v);
        chk("flags cleared", 16'h0000, v);
        chk("irq clear", 16'h0000, timer2_irq);
    endtask
    task automatic t_split();
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] v;
        high_byte_clock_select = 1'b1;
        wr(`T2CAP_ADDR_CTRL, 8'h08);
        wr(`T2CAP_ADDR_CNTH, 8'h12);
        wr(`T2CAP_ADDR_CNTL, 8'h10);
        rd(`T2CAP_ADDR_CNTL, a);
        repeat (20) @(negedge clk_sys);
        rd(`T2CAP_ADDR_CNTH, v);
        rd(`T2CAP_ADDR_CNTL, b);
        chk("high gated", 16'h0012, v);
        chk("low runs", 8'(a + 8'h16), b);
    endtask
    initial begin
        n_fail = 0;
        n_checks = 0;
        reset = 1'b1;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        low_byte_clock_select = 1'b0;
        high_byte_clock_select = 1'b0;
        timer_irq_enable = 1'b0;
        osc_run = 1'b0;
        repeat (5) @(negedge clk_sys);
        reset = 1'b0;
        t_regs();
        t_cap(1'b1, 8'h14, 16'd80, 16'd81);
        t_cap(1'b0, 8'h14, 16'd6, 16'd7);
        t_cap(1'b0, 8'h15, 16'd1, 16'd1);
        t_ovf();
        t_split();
        summarize();
    end
endmodule
